// ===== common/spp_pkg.sv
// shared constants and types for the serial port protocol configuration block
package spp_pkg;
  localparam int FRAME_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int CNT_BITS = 5;
  localparam logic [5:0] ADDR_IN_CTRL = 6'h08;
  localparam logic [5:0] ADDR_OUT_CTRL = 6'h0C;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam int OP_MSB = 15;
  localparam int ADDR_MSB = 13;
  localparam int IN_FMT_LSB = 0;
  localparam int OUT_SEL_LSB = 0;
  localparam int CLK_SRC_BIT = 6;
  localparam int PIN_FN_LSB = 8;
  localparam int GPO_BIT = 12;
  localparam logic [1:0] IN_FMT_RST = 2'h0;
  localparam logic [1:0] OUT_SEL_RST = 2'h0;
  localparam logic [1:0] PIN_FN_RST = 2'h0;
  localparam logic CLK_SRC_RST = 1'h0;
  localparam logic GPO_RST = 1'h0;
  localparam logic [1:0] OUT_SEL_SYNC = 2'h3;
  localparam logic [1:0] OUT_SEL_BAD = 2'h2;
  typedef enum logic [1:0] {
    PIN_TRISTATE,
    PIN_ALARM,
    PIN_GPO,
    PIN_DATA
  } spp_pin_fn_type;
endpackage

// ===== common/spp_link_if.sv
// signals between the configuration core and the serial link logic
`timescale 1ns/1ps
interface spp_link_if;
  logic rst;
  logic cpol;
  logic cpha;
  logic two_lane;
  logic [7:0] rd_byte;
  logic [15:0] cmd_word;
  logic cmd_tgl;
  logic lane0;
  logic lane1;
  modport link (
    input rst,
    input cpol,
    input cpha,
    input two_lane,
    input rd_byte,
    output cmd_word,
    output cmd_tgl,
    output lane0,
    output lane1
  );
  modport ctrl (
    output rst,
    output cpol,
    output cpha,
    output two_lane,
    output rd_byte,
    input cmd_word,
    input cmd_tgl,
    input lane0,
    input lane1
  );
endinterface

// ===== src/spp_sync2.sv
// two flip-flop synchroniser for levels and toggles
`timescale 1ns/1ps
module spp_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } spp_sync_type;

  spp_sync_type s_r;
  spp_sync_type s_nxt;

  always_comb begin
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
    if (srst) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  assign q = s_r.s2;
endmodule

// ===== src/spp_link.sv
// serial link logic on the host clock: frame capture and output lanes
`timescale 1ns/1ps
module spp_link (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  spp_link_if.link port
);
  typedef struct packed {
    logic [spp_pkg::CNT_BITS-1:0] cnt;
    logic [spp_pkg::FRAME_BITS-1:0] sh;
  } spp_smp_type;
  typedef struct packed {
    logic [spp_pkg::FRAME_BITS-1:0] word;
    logic tgl;
  } spp_cap_type;
  typedef struct packed {
    logic [spp_pkg::CNT_BITS-1:0] lc;
    logic [7:0] sh;
  } spp_lau_type;

  localparam logic [spp_pkg::CNT_BITS-1:0] LAST_BIT = 5'h0F;
  localparam logic [spp_pkg::CNT_BITS-1:0] CNT_SAT = 5'h10;

  logic eff_clk;
  logic frm_rst;
  logic [2:0] step;
  spp_smp_type s_r;
  spp_smp_type s_nxt;
  spp_cap_type c_r;
  spp_cap_type c_nxt;
  spp_lau_type l_r;
  spp_lau_type l_nxt;

  // sample edge is the rising edge of this clock in all four formats
  assign eff_clk = sclk ^ port.cpol ^ port.cpha;
  assign frm_rst = port.rst | cs_n;
  assign step = port.two_lane ? 3'h2 : 3'h1;

  always_comb begin
    s_nxt.sh = {s_r.sh[spp_pkg::FRAME_BITS-2:0], sdi};
    s_nxt.cnt = (s_r.cnt == CNT_SAT) ? s_r.cnt : s_r.cnt + 5'h01;
  end

  always_ff @(posedge eff_clk or posedge frm_rst) begin
    if (frm_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // a full frame is handed over by a toggle; the word stays until the next frame
  always_comb begin
    c_nxt = c_r;
    if (s_r.cnt == LAST_BIT) begin
      c_nxt.word = {s_r.sh[spp_pkg::FRAME_BITS-2:0], sdi};
      c_nxt.tgl = ~c_r.tgl;
    end
  end

  always_ff @(posedge eff_clk or posedge port.rst) begin
    if (port.rst) begin
      c_r <= '0;
    end else begin
      c_r <= c_nxt;
    end
  end

  // launch on the opposite edge; phase 1 presents the first bit at the first edge
  always_comb begin
    l_nxt.lc = (l_r.lc == CNT_SAT) ? l_r.lc : l_r.lc + 5'h01;
    if (l_r.lc == '0) begin
      l_nxt.sh = port.cpha ? port.rd_byte : port.rd_byte << step;
    end else begin
      l_nxt.sh = l_r.sh << step;
    end
  end

  always_ff @(negedge eff_clk or posedge frm_rst) begin
    if (frm_rst) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  assign port.cmd_word = c_r.word;
  assign port.cmd_tgl = c_r.tgl;
  assign port.lane0 = (l_r.lc == '0) ? port.rd_byte[7] : l_r.sh[7];
  assign port.lane1 = (l_r.lc == '0) ? port.rd_byte[6] : l_r.sh[6];

  property p_two_lane_shift;
    @(negedge eff_clk) disable iff (frm_rst)
      (port.two_lane && l_r.lc != '0 && l_r.lc < 5'h04) |=> (l_r.sh == ($past(l_r.sh) << 2));
  endproperty
  a_two_lane_shift: assert property (p_two_lane_shift)
    else $error("two-lane output did not advance two bits per edge");
endmodule

// ===== src/spp_config_top.sv
// configuration core of the serial host port with its link logic
`timescale 1ns/1ps
module spp_config_top (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  input wire logic alarm_in,
  output logic gpo_pin,
  output logic sdo0_o,
  output logic sdo0_oe,
  output logic sdo1_o,
  output logic sdo1_oe,
  output logic sync_strobe
);
  typedef struct packed {
    logic [1:0] in_fmt;
    logic [1:0] out_sel;
    spp_pkg::spp_pin_fn_type pin_fn;
    logic clk_src;
    logic gpo_lvl;
    logic app_cpol;
    logic app_cpha;
    logic app_two;
    logic [7:0] rd_byte;
    logic tgl_seen;
    logic lnk_rst;
    logic gpo_pin;
  } spp_state_type;

  spp_state_type s_r;
  spp_state_type s_nxt;
  spp_link_if lnk ();
  logic [1:0] sync_q;
  logic cs_idle;
  logic take;
  logic [1:0] op;
  logic [5:0] addr;
  logic [7:0] data;
  logic is_wr;
  logic is_rd;

  spp_sync2 #(
    .W(2)
  ) u_sync (
    .clk(sys_clk),
    .srst(srst),
    .d({spi_cs_n, lnk.cmd_tgl}),
    .q(sync_q)
  );

  spp_link u_link (
    .sclk(spi_sclk),
    .cs_n(spi_cs_n),
    .sdi(spi_sdi),
    .port(lnk.link)
  );

  assign cs_idle = sync_q[1];
  assign take = sync_q[0] != s_r.tgl_seen;
  assign op = lnk.cmd_word[spp_pkg::OP_MSB -: 2];
  assign addr = lnk.cmd_word[spp_pkg::ADDR_MSB -: 6];
  assign data = lnk.cmd_word[spp_pkg::BYTE_BITS-1:0];
  assign is_wr = take && op == spp_pkg::OP_WRITE;
  assign is_rd = take && op == spp_pkg::OP_READ;

  // whole 32-bit register at the word holding a byte address; unmapped reads zero
  function automatic logic [31:0] reg_word(input spp_state_type s, input logic [5:0] a);
    logic [31:0] w;
    w = '0;
    if (a[5:2] == spp_pkg::ADDR_IN_CTRL[5:2]) begin
      w[spp_pkg::IN_FMT_LSB +: 2] = s.in_fmt;
    end else if (a[5:2] == spp_pkg::ADDR_OUT_CTRL[5:2]) begin
      w[spp_pkg::OUT_SEL_LSB +: 2] = s.out_sel;
      w[spp_pkg::CLK_SRC_BIT] = s.clk_src;
      w[spp_pkg::PIN_FN_LSB +: 2] = s.pin_fn;
      w[spp_pkg::GPO_BIT] = s.gpo_lvl;
    end
    return w;
  endfunction

  always_comb begin
    logic [31:0] w;
    logic [4:0] lane;
    w = reg_word(s_r, addr);
    lane = {addr[1:0], 3'h0};
    s_nxt = s_r;
    s_nxt.lnk_rst = 1'b0;
    s_nxt.gpo_pin = s_r.gpo_lvl;
    // applied clock modes only move while no frame is running
    if (cs_idle) begin
      s_nxt.app_cpol = s_r.in_fmt[1];
      s_nxt.app_cpha = s_r.in_fmt[0];
      s_nxt.app_two = s_r.pin_fn == spp_pkg::PIN_DATA;
    end
    if (take) begin
      s_nxt.tgl_seen = sync_q[0];
    end
    if (is_wr) begin
      w[lane +: 8] = data;
      // only defined fields are taken from the merged word
      if (addr[5:2] == spp_pkg::ADDR_IN_CTRL[5:2]) begin
        s_nxt.in_fmt = w[spp_pkg::IN_FMT_LSB +: 2];
      end else if (addr[5:2] == spp_pkg::ADDR_OUT_CTRL[5:2]) begin
        s_nxt.out_sel = w[spp_pkg::OUT_SEL_LSB +: 2];
        s_nxt.clk_src = w[spp_pkg::CLK_SRC_BIT];
        s_nxt.pin_fn = spp_pkg::spp_pin_fn_type'(w[spp_pkg::PIN_FN_LSB +: 2]);
        s_nxt.gpo_lvl = w[spp_pkg::GPO_BIT];
      end
    end else if (is_rd) begin
      s_nxt.rd_byte = w[lane +: 8];
    end
    if (srst) begin
      s_nxt = '0;
      s_nxt.in_fmt = spp_pkg::IN_FMT_RST;
      s_nxt.out_sel = spp_pkg::OUT_SEL_RST;
      s_nxt.pin_fn = spp_pkg::spp_pin_fn_type'(spp_pkg::PIN_FN_RST);
      s_nxt.clk_src = spp_pkg::CLK_SRC_RST;
      s_nxt.gpo_lvl = spp_pkg::GPO_RST;
      s_nxt.gpo_pin = spp_pkg::GPO_RST;
      s_nxt.lnk_rst = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    s_r <= s_nxt;
  end

  assign lnk.rst = s_r.lnk_rst;
  assign lnk.cpol = s_r.app_cpol;
  assign lnk.cpha = s_r.app_cpha;
  assign lnk.two_lane = s_r.app_two;
  assign lnk.rd_byte = s_r.rd_byte;

  assign gpo_pin = s_r.gpo_pin;
  assign sdo0_o = lnk.lane0;
  assign sdo0_oe = ~spi_cs_n;

  // second output pin function
  always_comb begin
    unique case (s_r.pin_fn)
      spp_pkg::PIN_TRISTATE: begin
        sdo1_o = 1'b0;
        sdo1_oe = 1'b0;
      end
      spp_pkg::PIN_ALARM: begin
        sdo1_o = alarm_in;
        sdo1_oe = 1'b1;
      end
      spp_pkg::PIN_GPO: begin
        sdo1_o = s_r.gpo_pin;
        sdo1_oe = 1'b1;
      end
      spp_pkg::PIN_DATA: begin
        sdo1_o = lnk.lane1;
        sdo1_oe = ~spi_cs_n;
      end
    endcase
  end

  // strobe only in synchronous mode; code 10b behaves as follow mode
  assign sync_strobe = (s_r.out_sel == spp_pkg::OUT_SEL_SYNC) ?
    (s_r.clk_src ? sys_clk : spi_sclk) : 1'b0;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  property p_reset_fmt;
    disable iff (1'b0) srst |=> (s_r.in_fmt == 2'h0 && lnk.cpol == 1'b0) ##1 (lnk.cpha == 1'b0);
  endproperty
  a_reset_fmt: assert property (p_reset_fmt)
    else $error("input format not zero after reset");

  property p_gpo_write;
    (is_wr && addr == 6'h0D) |-> ##2 (gpo_pin == $past(data[4], 2));
  endproperty
  a_gpo_write: assert property (p_gpo_write)
    else $error("general output pin did not follow written level");

  property p_pin_tristate;
    (s_r.pin_fn == spp_pkg::PIN_TRISTATE) |-> !sdo1_oe;
  endproperty
  a_pin_tristate: assert property (p_pin_tristate)
    else $error("second pin driven while released");

  property p_pin_alarm;
    (s_r.pin_fn == spp_pkg::PIN_ALARM) |-> (sdo1_oe && sdo1_o == alarm_in);
  endproperty
  a_pin_alarm: assert property (p_pin_alarm)
    else $error("second pin not carrying alarm");

  property p_pin_gpo;
    (s_r.pin_fn == spp_pkg::PIN_GPO && $stable(s_r.gpo_lvl))[*2] |-> (sdo1_o == s_r.gpo_lvl);
  endproperty
  a_pin_gpo: assert property (p_pin_gpo)
    else $error("second pin not carrying general output");

  property p_in_readback;
    (is_rd && addr == 6'h08) |=> (s_r.rd_byte[7:2] == 6'h00 && s_r.rd_byte[1:0] == $past(s_r.in_fmt));
  endproperty
  a_in_readback: assert property (p_in_readback)
    else $error("input control readback wrong");

  property p_out_readback;
    (is_rd && addr == 6'h0D) |=> (s_r.rd_byte[7:5] == 3'h0 && s_r.rd_byte[3:2] == 2'h0);
  endproperty
  a_out_readback: assert property (p_out_readback)
    else $error("output control reserved bits not zero");

  property p_out_write;
    (is_wr && addr == 6'h0C) |=> (s_r.out_sel == $past(data[1:0]) && s_r.clk_src == $past(data[6]));
  endproperty
  a_out_write: assert property (p_out_write)
    else $error("output control low byte not stored");

  property p_upper_bytes;
    (is_wr && addr[5:2] == 4'h2 && addr[1:0] != 2'h0) |=> $stable(s_r.in_fmt);
  endproperty
  a_upper_bytes: assert property (p_upper_bytes)
    else $error("write to upper byte changed input format");

  property p_mode_frozen;
    !cs_idle |=> $stable({s_r.app_cpol, s_r.app_cpha, s_r.app_two});
  endproperty
  a_mode_frozen: assert property (p_mode_frozen)
    else $error("clock mode changed during a frame");

  property p_mode_apply;
    (cs_idle && $stable(s_r.in_fmt))[*2] |-> ({lnk.cpol, lnk.cpha} == s_r.in_fmt);
  endproperty
  a_mode_apply: assert property (p_mode_apply)
    else $error("idle link not using programmed clock mode");

  property p_strobe_off;
    (s_r.out_sel != spp_pkg::OUT_SEL_SYNC) |-> (sync_strobe == 1'b0);
  endproperty
  a_strobe_off: assert property (p_strobe_off)
    else $error("strobe active outside synchronous mode");

  property p_strobe_host;
    (s_r.out_sel == spp_pkg::OUT_SEL_SYNC && !s_r.clk_src) |-> (sync_strobe == spi_sclk);
  endproperty
  a_strobe_host: assert property (p_strobe_host)
    else $error("strobe not following host serial clock");

  property p_lane_pair;
    (s_r.pin_fn == spp_pkg::PIN_DATA) |-> (sdo1_oe == !spi_cs_n && sdo1_o == lnk.lane1);
  endproperty
  a_lane_pair: assert property (p_lane_pair)
    else $error("second pin not carrying second data lane");

  property p_idle_lane;
    spi_cs_n |-> (!sdo0_oe && sdo0_o == s_r.rd_byte[7]);
  endproperty
  a_idle_lane: assert property (p_idle_lane)
    else $error("first lane not parked on leading read bit");

  property p_pin_write;
    (is_wr && addr == 6'h0D) |=>
      (s_r.pin_fn == $past(data[1:0]) && s_r.gpo_lvl == $past(data[4]));
  endproperty
  a_pin_write: assert property (p_pin_write)
    else $error("second pin function or output level not stored");

  property p_unmapped_write;
    (is_wr && addr[5:2] != spp_pkg::ADDR_IN_CTRL[5:2] &&
      addr[5:2] != spp_pkg::ADDR_OUT_CTRL[5:2]) |=>
      ($stable(s_r.in_fmt) && $stable(s_r.out_sel) && $stable(s_r.pin_fn) &&
      $stable(s_r.clk_src) && $stable(s_r.gpo_lvl));
  endproperty
  a_unmapped_write: assert property (p_unmapped_write)
    else $error("write to unmapped address changed a field");

  property p_unmapped_read;
    (is_rd && addr[5:2] != spp_pkg::ADDR_IN_CTRL[5:2] &&
      addr[5:2] != spp_pkg::ADDR_OUT_CTRL[5:2]) |=> (s_r.rd_byte == 8'h00);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped address did not read zero");

  property p_in_upper_read;
    (is_rd && addr[5:2] == spp_pkg::ADDR_IN_CTRL[5:2] && addr[1:0] != 2'h0) |=>
      (s_r.rd_byte == 8'h00);
  endproperty
  a_in_upper_read: assert property (p_in_upper_read)
    else $error("input control upper byte not zero");

  property p_out_low_read;
    (is_rd && addr == 6'h0C) |=> (s_r.rd_byte[7] == 1'b0 && s_r.rd_byte[5:2] == 4'h0 &&
      s_r.rd_byte[1:0] == $past(s_r.out_sel) && s_r.rd_byte[6] == $past(s_r.clk_src));
  endproperty
  a_out_low_read: assert property (p_out_low_read)
    else $error("output control low byte readback wrong");

  property p_out_upper_read;
    (is_rd && addr[5:2] == spp_pkg::ADDR_OUT_CTRL[5:2] && addr[1] == 1'b1) |=>
      (s_r.rd_byte == 8'h00);
  endproperty
  a_out_upper_read: assert property (p_out_upper_read)
    else $error("output control upper bytes not zero");
endmodule

// ===== testbench/spp_host_model.sv
// host controller model that frames commands on the serial port
`timescale 1ns/1ps
module spp_host_model (
  input wire logic clk,
  input wire logic req,
  input wire logic [15:0] word,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic sdo0,
  input wire logic sdo1,
  output logic ack,
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  output logic [15:0] rx0,
  output logic [15:0] rx1
);
  task automatic cap;
    rx0 = {rx0[14:0], sdo0};
    rx1 = {rx1[14:0], sdo1};
  endtask
  initial begin
    ack = 1'b0;
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
    rx0 = 16'h0000;
    rx1 = 16'h0000;
    forever begin
      @(posedge clk iff req);
      sclk = cpol;
      #20 cs_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
        if (!cpha) sdi = word[i];
        #15;
        if (!cpha) cap();
        sclk = ~cpol;
        if (cpha) sdi = word[i];
        #15;
        if (cpha) cap();
        sclk = cpol;
      end
      #15 cs_n = 1'b1;
      // released data line shows the inverse of its last bit
      sdi = ~sdi;
      #400;
      @(posedge clk) ack <= 1'b1;
      @(posedge clk) ack <= 1'b0;
    end
  end
endmodule

// ===== testbench/spp_config_top_tb.sv
// self-checking bench for the serial port configuration block
`timescale 1ns/1ps
module spp_config_top_tb;
  localparam int LIMIT = 8000;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic alarm_in = 1'b0;
  logic req = 1'b0;
  logic [15:0] word = 16'h0000;
  logic cpol = 1'b0;
  logic cpha = 1'b0;
  logic tl = 1'b0;
  logic ack, spi_sclk, spi_cs_n, spi_sdi;
  logic gpo_pin, sdo0_o, sdo0_oe, sdo1_o, sdo1_oe, sync_strobe;
  logic lane0, lane1;
  logic [15:0] rx0, rx1;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  assign lane0 = sdo0_oe ? sdo0_o : ~sdo0_o;
  assign lane1 = sdo1_oe ? sdo1_o : ~sdo1_o;
  spp_config_top dut (
    .sys_clk(sys_clk),
    .srst(srst),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi),
    .alarm_in(alarm_in),
    .gpo_pin(gpo_pin),
    .sdo0_o(sdo0_o),
    .sdo0_oe(sdo0_oe),
    .sdo1_o(sdo1_o),
    .sdo1_oe(sdo1_oe),
    .sync_strobe(sync_strobe)
  );
  spp_host_model host (
    .clk(sys_clk),
    .req(req),
    .word(word),
    .cpol(cpol),
    .cpha(cpha),
    .sdo0(lane0),
    .sdo1(lane1),
    .ack(ack),
    .sclk(spi_sclk),
    .cs_n(spi_cs_n),
    .sdi(spi_sdi),
    .rx0(rx0),
    .rx1(rx1)
  );
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic [15:0] w);
    @(posedge sys_clk);
    word <= w;
    req <= 1'b1;
    do @(posedge sys_clk); while (ack !== 1'b1);
    req <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    xfer({spp_pkg::OP_WRITE, a, d});
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] b;
    xfer({spp_pkg::OP_READ, a, 8'h00});
    xfer(16'h0000);
    b = rx0[15:8];
    if (tl) b = {rx0[15], rx1[15], rx0[14], rx1[14], rx0[13], rx1[13], rx0[12], rx1[12]};
    chk($sformatf("byte %h", a), e, b);
  endtask
  task automatic pin(input logic [1:0] e);
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("second pin oe and value", {6'h00, e}, {6'h00, sdo1_oe, sdo1_o});
  endtask
  task automatic strb(input logic hi, input logic lo);
    @(posedge sys_clk);
    #1 chk("strobe high phase", {7'h00, hi}, {7'h00, sync_strobe});
    @(negedge sys_clk);
    #1 chk("strobe low phase", {7'h00, lo}, {7'h00, sync_strobe});
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (5) @(posedge sys_clk);
    chk("gpo_pin", 8'h00, {7'h00, gpo_pin});
    chk("sdo1_oe", 8'h00, {7'h00, sdo1_oe});
    chk("sync_strobe", 8'h00, {7'h00, sync_strobe});
    rd(6'h08, 8'h00);
    rd(6'h0C, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(6'h08, 8'hFC | 8'(m));
      {cpol, cpha} <= 2'(m);
      rd(6'h08, 8'(m));
    end
    wr(6'h09, 8'hFF);
    wr(6'h0B, 8'hFF);
    rd(6'h09, 8'h00);
    rd(6'h0B, 8'h00);
    wr(6'h0F, 8'hFF);
    rd(6'h0F, 8'h00);
    wr(6'h10, 8'hFF);
    rd(6'h10, 8'h00);
    wr(6'h0D, 8'hFF);
    tl = 1'b1;
    chk("gpo_pin", 8'h01, {7'h00, gpo_pin});
    chk("idle sdo1_oe", 8'h00, {7'h00, sdo1_oe});
    rd(6'h0D, 8'h13);
    wr(6'h0D, 8'h00);
    tl = 1'b0;
    chk("sdo1_oe", 8'h00, {7'h00, sdo1_oe});
    chk("gpo_pin", 8'h00, {7'h00, gpo_pin});
    wr(6'h0D, 8'h01);
    alarm_in <= 1'b1;
    pin(2'b11);
    alarm_in <= 1'b0;
    pin(2'b10);
    wr(6'h0D, 8'h12);
    pin(2'b11);
    wr(6'h0D, 8'h02);
    pin(2'b10);
    wr(6'h0C, 8'hFF);
    strb(1'b1, 1'b0);
    rd(6'h0C, 8'h43);
    wr(6'h0C, 8'h03);
    strb(1'b1, 1'b1);
    wr(6'h0C, 8'h40);
    strb(1'b0, 1'b0);
    rd(6'h0C, 8'h40);
    close_out();
  end
endmodule
